// ===== rtl/cgrf_pkg.sv
// package for the core general register file: sizes, selectors, reset sequence states
// assumes one core clock and a datapath that drives register requests
package cgrf_pkg;
    localparam int NUM_REGS  = 8;
    localparam int REG_W     = 32;
    localparam int IDX_W     = 3;
    localparam int PC_W      = 24;
    localparam int CCR_W     = 8;
    localparam int CCR_IMASK = 7;
    localparam logic [IDX_W-1:0] SP_IDX = 3'h7;

    // width selector for each access
    typedef enum logic [1:0] {
        CGRF_LONG  = 2'h0,
        CGRF_UHALF = 2'h1,
        CGRF_LHALF = 2'h2,
        CGRF_BYTE  = 2'h3
    } cgrf_width_e;

    // byte select when width is CGRF_BYTE
    localparam logic BYTE_HIGH = 1'h1;

    // reset sequence states, gray along the path
    typedef enum logic [1:0] {
        CGRF_RST_IDLE = 2'h0,
        CGRF_RST_WAIT = 2'h1,
        CGRF_RST_RUN  = 2'h3
    } cgrf_rst_e;
endpackage

// ===== rtl/cgrf_acc_if.sv
`timescale 1ns/100ps
// interface carrying one width-selected register access between the modules
// assumes one core clock domain
interface cgrf_acc_if;
    import cgrf_pkg::*;
    logic [IDX_W-1:0] idx;
    cgrf_width_e      width;
    logic             byte_hi;
    logic [REG_W-1:0] wdata;
    logic [REG_W-1:0] old_val;
    logic [REG_W-1:0] merged;
    logic [REG_W-1:0] rdata;
    modport top  (output idx, width, byte_hi, wdata, old_val, input merged, rdata);
    modport lane (input idx, width, byte_hi, wdata, old_val, output merged, rdata);
endinterface

// ===== rtl/cgrf_lane.sv
`timescale 1ns/100ps
// width lane: extracts a read piece and merges a write piece into a word
// assumes width selectors from cgrf_pkg; purely combinational
module cgrf_lane
    import cgrf_pkg::*;
(
    cgrf_acc_if.lane acc
);
    always_comb begin
        acc.merged = acc.old_val;
        acc.rdata  = '0;
        case (acc.width)
            CGRF_LONG: begin
                acc.merged = acc.wdata;
                acc.rdata  = acc.old_val;
            end
            CGRF_UHALF: begin
                acc.merged[31:16] = acc.wdata[15:0];
                acc.rdata[15:0]   = acc.old_val[31:16];
            end
            CGRF_LHALF: begin
                acc.merged[15:0] = acc.wdata[15:0];
                acc.rdata[15:0]  = acc.old_val[15:0];
            end
            CGRF_BYTE: begin
                if (acc.byte_hi == BYTE_HIGH) begin
                    acc.merged[15:8] = acc.wdata[7:0];
                    acc.rdata[7:0]   = acc.old_val[15:8];
                end else begin
                    acc.merged[7:0] = acc.wdata[7:0];
                    acc.rdata[7:0]  = acc.old_val[7:0];
                end
            end
            default: begin
                acc.merged = acc.old_val;
            end
        endcase
    end
endmodule

// ===== rtl/cgrf_regfile.sv
`timescale 1ns/100ps
// core general register file with program counter and condition flags
// assumes the datapath drives requests synchronous to CLK
module cgrf_regfile
    import cgrf_pkg::*;
#(
    parameter int NREGS = NUM_REGS
)
(
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    // width-selected access, one read and one write port
    input  wire logic                  RD_EN,
    input  wire logic [IDX_W-1:0]      RD_IDX,
    input  wire cgrf_pkg::cgrf_width_e RD_WIDTH,
    input  wire logic                  RD_BYTE_HI,
    output logic      [REG_W-1:0]      RD_DATA,
    input  wire logic                  WR_EN,
    input  wire logic [IDX_W-1:0]      WR_IDX,
    input  wire cgrf_pkg::cgrf_width_e WR_WIDTH,
    input  wire logic                  WR_BYTE_HI,
    input  wire logic [REG_W-1:0]      WR_DATA,
    // stack pointer port
    input  wire logic                  SP_WR_EN,
    input  wire logic [REG_W-1:0]      SP_WR_DATA,
    output logic      [REG_W-1:0]      SP_DATA,
    // program counter
    input  wire logic                  PC_WR_EN,
    input  wire logic [PC_W-1:0]       PC_WR_DATA,
    input  wire logic                  VEC_VALID,
    input  wire logic [PC_W-1:0]       VEC_DATA,
    output logic      [PC_W-1:0]       PC_VALUE,
    output logic      [PC_W-1:0]       FETCH_ADDR,
    output logic                       RST_SEQ_BUSY,
    // condition flags
    input  wire logic                  CCR_WR_EN,
    input  wire logic [CCR_W-1:0]      CCR_WR_DATA,
    output logic      [CCR_W-1:0]      CCR_VALUE
);
    import cgrf_pkg::*;

    // index width is fixed by the package, so only eight registers can be reached
    generate
        if (NREGS != NUM_REGS) begin : g_bad_nregs
            $error("cgrf_regfile: NREGS must equal eight");
        end
    endgenerate

    logic [REG_W-1:0] gr_r   [NREGS];
    logic [REG_W-1:0] gr_nxt [NREGS];
    logic [PC_W-1:0]  pc_r, pc_nxt;
    logic [PC_W-1:0]  fetch_r, fetch_nxt;
    logic [CCR_W-1:0] ccr_r, ccr_nxt;
    logic [REG_W-1:0] rd_r, rd_nxt;
    logic [REG_W-1:0] sp_r, sp_nxt;
    cgrf_rst_e        rst_r, rst_nxt;
    logic             busy_r, busy_nxt;

    cgrf_acc_if wacc();
    cgrf_acc_if racc();

    cgrf_lane u_wlane (.acc(wacc));
    cgrf_lane u_rlane (.acc(racc));

    // enable and index decode used by the write port only
    function automatic logic hit(input logic en, input logic [IDX_W-1:0] a,
                                 input logic [IDX_W-1:0] b);
        hit = en && (a == b);
    endfunction

    // control register loads are only honoured once the sequence has finished
    function automatic logic running(input cgrf_rst_e st);
        running = (st == CGRF_RST_RUN);
    endfunction

    assign wacc.idx     = WR_IDX;
    assign wacc.width   = WR_WIDTH;
    assign wacc.byte_hi = WR_BYTE_HI;
    assign wacc.wdata   = WR_DATA;
    assign wacc.old_val = gr_r[WR_IDX];
    assign racc.idx     = RD_IDX;
    assign racc.width   = RD_WIDTH;
    assign racc.byte_hi = RD_BYTE_HI;
    assign racc.wdata   = '0;
    assign racc.old_val = gr_r[RD_IDX];

    // general registers; the datapath port wins over the implicit sp port
    generate
        for (genvar g = 0; g < NREGS; g++) begin : g_gr
            always_comb begin
                gr_nxt[g] = gr_r[g];
                if (hit(WR_EN, WR_IDX, IDX_W'(g))) begin
                    gr_nxt[g] = wacc.merged;
                end else if (SP_WR_EN && (IDX_W'(g) == SP_IDX)) begin
                    gr_nxt[g] = SP_WR_DATA;
                end
            end
            // data registers carry no reset: contents undefined after power-up
            always_ff @(posedge CLK) begin
                gr_r[g] <= gr_nxt[g];
            end
        end
    endgenerate

    // reset exception sequence: wait for the start address from the vector
    // idle lasts one edge so a vector offered on the release edge is not taken
    always_comb begin
        rst_nxt  = rst_r;
        busy_nxt = busy_r;
        case (rst_r)
            CGRF_RST_IDLE: begin
                rst_nxt  = CGRF_RST_WAIT;
                busy_nxt = 1'b1;
            end
            CGRF_RST_WAIT: begin
                if (VEC_VALID) begin
                    rst_nxt  = CGRF_RST_RUN;
                    busy_nxt = 1'b0;
                end
            end
            CGRF_RST_RUN: begin
                rst_nxt  = CGRF_RST_RUN;
                busy_nxt = 1'b0;
            end
            default: begin
                // unreachable encoding: restart the sequence
                rst_nxt  = CGRF_RST_IDLE;
                busy_nxt = 1'b1;
            end
        endcase
    end

    // sequencer and read register are the only state with a true reset value
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rst_r  <= CGRF_RST_IDLE;
            busy_r <= 1'b1;
        end else begin
            rst_r  <= rst_nxt;
            busy_r <= busy_nxt;
        end
    end

    // program counter: vector load first, then datapath loads once running
    // no reset value of its own; the vector load is its only initialiser
    always_comb begin
        pc_nxt = pc_r;
        if (!RESET) begin
            if ((rst_r == CGRF_RST_WAIT) && VEC_VALID) begin
                pc_nxt = VEC_DATA;
            end else if (running(rst_r) && PC_WR_EN) begin
                pc_nxt = PC_WR_DATA;
            end
        end
        // fetch address kept in its own flop so the output needs no gate
        fetch_nxt    = pc_nxt;
        fetch_nxt[0] = 1'b0;
    end

    always_ff @(posedge CLK) begin
        pc_r    <= pc_nxt;
        fetch_r <= fetch_nxt;
    end

    // condition flags: mask bit forced on at reset, the rest keep their value
    // a flag write on a reset edge is dropped so the mask bit always wins
    always_comb begin
        ccr_nxt = ccr_r;
        if (RESET) begin
            ccr_nxt[CCR_IMASK] = 1'b1;
        end else if (running(rst_r) && CCR_WR_EN) begin
            ccr_nxt = CCR_WR_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        ccr_r <= ccr_nxt;
    end

    // read port: registered piece, held while no read is asked for
    // reads see the value before this edge's write, never a bypass
    always_comb begin
        rd_nxt = rd_r;
        if (RD_EN) begin
            rd_nxt = racc.rdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rd_r <= '0;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    // stack pointer view follows register seven after this edge's writes
    // costs a second copy of the word but keeps the output a plain flop
    always_comb begin
        sp_nxt = gr_nxt[SP_IDX];
    end

    always_ff @(posedge CLK) begin
        sp_r <= sp_nxt;
    end

    assign RD_DATA      = rd_r;
    assign SP_DATA      = sp_r;
    assign PC_VALUE     = pc_r;
    assign FETCH_ADDR   = fetch_r;
    assign RST_SEQ_BUSY = busy_r;
    assign CCR_VALUE    = ccr_r;
endmodule

// ===== tb/cgrf_chk.sv
// checker: port assertions of the register file
// assumes bind into cgrf_regfile, one clock
`timescale 1ns/100ps
module cgrf_chk
    import cgrf_pkg::*;
(
    input wire logic        CLK, RESET, RD_EN, WR_EN, SP_WR_EN, PC_WR_EN, CCR_WR_EN,
    input wire logic        VEC_VALID, RST_SEQ_BUSY,
    input wire logic [2:0]  RD_IDX, WR_IDX,
    input wire cgrf_pkg::cgrf_width_e RD_WIDTH, WR_WIDTH,
    input wire logic [31:0] WR_DATA, SP_WR_DATA, RD_DATA, SP_DATA,
    input wire logic [23:0] PC_WR_DATA, VEC_DATA, PC_VALUE, FETCH_ADDR,
    input wire logic [7:0]  CCR_WR_DATA, CCR_VALUE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_take; (!RESET) [*3] ##0 RST_SEQ_BUSY && VEC_VALID; endsequence
    sequence s_pair; WR_EN && WR_WIDTH == CGRF_LONG ##1
        RD_EN && RD_WIDTH == CGRF_LONG && RD_IDX == $past(WR_IDX); endsequence
    a_reset_state: assert property (disable iff (1'b0) RESET && !RD_EN |=>
        RST_SEQ_BUSY && CCR_VALUE[CCR_IMASK] && RD_DATA == '0) else $error("bad reset");
    a_vec_load: assert property (s_take |=> PC_VALUE == $past(VEC_DATA)) else $error("bad vec");
    a_pc_load: assert property (!RST_SEQ_BUSY && PC_WR_EN |=> PC_VALUE == $past(PC_WR_DATA))
        else $error("bad pc");
    a_fetch_even: assert property (!RST_SEQ_BUSY |-> FETCH_ADDR == {PC_VALUE[23:1], 1'b0})
        else $error("bad fetch");
    a_ccr_write: assert property (!RST_SEQ_BUSY && CCR_WR_EN |=> CCR_VALUE == $past(CCR_WR_DATA))
        else $error("bad flags");
    a_sp_port: assert property (SP_WR_EN && !(WR_EN && WR_IDX == SP_IDX) |=>
        SP_DATA == $past(SP_WR_DATA)) else $error("bad sp");
    a_long_echo: assert property (s_pair |=> RD_DATA == $past(WR_DATA, 2)) else $error("bad word");
    a_byte_piece: assert property (RD_EN && RD_WIDTH == CGRF_BYTE |=> RD_DATA[31:8] == '0)
        else $error("bad byte");
endmodule
bind cgrf_regfile cgrf_chk chk (.*);

// ===== tb/cgrf_vec_model.sv
// vector source standing in for the fetch path at reset
// assumes RST_SEQ_BUSY of cgrf_regfile
`timescale 1ns/100ps
module cgrf_vec_model #(parameter logic [23:0] START = 24'h000100)
(
    input  wire logic   CLK, RESET, RST_SEQ_BUSY,
    output logic        VEC_VALID = 1'h0,
    output logic [23:0] VEC_DATA = 24'h0
);
    int n = 0;
    // late answer like a real fetch; idle data toggles so it is never stale
    always @(posedge CLK) begin
        n <= RESET || !RST_SEQ_BUSY ? 0 : n + 1;
        VEC_VALID <= !RESET && RST_SEQ_BUSY && n > 2;
        VEC_DATA <= !RESET && RST_SEQ_BUSY && n > 2 ? START : ~VEC_DATA;
    end
endmodule

// ===== tb/cgrf_regfile_test.sv
// bench: random width accesses against a register model
// assumes the bound checker and cgrf_vec_model
`timescale 1ns/100ps
module cgrf_regfile_test;
    import cgrf_pkg::*;
    localparam logic [23:0] START = 24'h01A5B3;
    logic CLK = 0, RESET = 1, RD_EN = 0, RD_BYTE_HI = 0, WR_EN = 0, WR_BYTE_HI = 0, run = 0;
    logic SP_WR_EN = 0, PC_WR_EN = 0, CCR_WR_EN = 0, VEC_VALID, RST_SEQ_BUSY;
    logic [2:0] RD_IDX = 0, WR_IDX = 0;
    cgrf_width_e RD_WIDTH = CGRF_LONG, WR_WIDTH = CGRF_LONG;
    logic [31:0] WR_DATA = 0, SP_WR_DATA = 0, RD_DATA, SP_DATA, e_rd = 0, r, m [8];
    logic [23:0] PC_WR_DATA = 0, VEC_DATA, PC_VALUE, FETCH_ADDR, e_pc = START;
    logic [7:0] CCR_WR_DATA = 0, CCR_VALUE, e_ccr = 8'h3C;
    int err_total = 0, checks_done = 0, s;
    cgrf_regfile dut (.*);
    cgrf_vec_model #(.START(START)) vec (.*);
    initial forever #5 CLK = ~CLK;
    function automatic int sh(cgrf_width_e w, logic h);
        return w == CGRF_UHALF ? 16 : (w == CGRF_BYTE && h) ? 8 : 0;
    endfunction
    function automatic logic [31:0] mk(cgrf_width_e w);
        return w == CGRF_LONG ? '1 : w == CGRF_BYTE ? 32'hFF : 32'hFFFF;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] v);
        checks_done++;
        if (v !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic print_verdict;
        if (err_total == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // flag and pc writes offered during reset and the first two edges after release must be refused
    task automatic do_reset(int n);
        RESET <= 1;
        {PC_WR_EN, CCR_WR_EN, CCR_WR_DATA} <= 10'h300;
        repeat (n) @(posedge CLK);
        RESET <= 0;
        repeat (2) @(posedge CLK);
        {PC_WR_EN, CCR_WR_EN} <= 2'h0;
        for (int i = 0; i < 20 && RST_SEQ_BUSY !== 0; i++) @(negedge CLK);
        chk("PC", START, PC_VALUE);
        chk("CCR_I", 1, CCR_VALUE[CCR_IMASK]);
    endtask
    always @(posedge CLK) if (run) begin
        s = sh(RD_WIDTH, RD_BYTE_HI);
        if (RD_EN) e_rd = m[RD_IDX] >> s & mk(RD_WIDTH);
        s = sh(WR_WIDTH, WR_BYTE_HI);
        if (SP_WR_EN) m[SP_IDX] = SP_WR_DATA;
        if (WR_EN) m[WR_IDX] ^= (m[WR_IDX] ^ WR_DATA << s) & mk(WR_WIDTH) << s;
        if (PC_WR_EN) e_pc = PC_WR_DATA;
        if (CCR_WR_EN) e_ccr = CCR_WR_DATA;
        @(negedge CLK);
        chk("RD", e_rd, RD_DATA);
        chk("SP", m[SP_IDX], SP_DATA);
        chk("FETCH", e_pc & 24'hFFFFFE, FETCH_ADDR);
        chk("CONDITION_FLAGS_REGISTER", e_ccr, CCR_VALUE);
    end
    initial begin
        void'($urandom(15));
        do_reset(4);
        for (int i = 0; i < 8; i++) begin
            @(posedge CLK);
            m[i] = $urandom;
            {WR_EN, WR_IDX, WR_DATA, CCR_WR_EN, CCR_WR_DATA} <= {1'b1, 3'(i), m[i], 9'h13C};
        end
        @(posedge CLK);
        {WR_EN, CCR_WR_EN, run} <= 3'h1;
        repeat (3000) begin
            @(posedge CLK);
            r = $urandom;
            {WR_EN, WR_IDX, WR_BYTE_HI, RD_EN, RD_BYTE_HI, PC_WR_EN, CCR_WR_EN} <= r[8:0];
            RD_IDX <= r[9] ? r[7:5] : r[12:10];
            WR_WIDTH <= cgrf_width_e'(r[14:13]);
            RD_WIDTH <= cgrf_width_e'(r[16:15]);
            SP_WR_EN <= r[17] & ~(r[8] & (&r[7:5]));
            WR_DATA <= r[18] ? $urandom : {32{r[19]}};
            {SP_WR_DATA, PC_WR_DATA, CCR_WR_DATA} <= {$urandom, $urandom};
        end
        @(posedge CLK);
        run <= 0;
        do_reset(2);
        print_verdict;
    end
    initial begin
        #100000;
        err_total++;
        print_verdict;
    end
endmodule
